// file: shared_memory_arbiter_user_pins.sv
// arbiter for shared buffer memory and register access, with user pins
module shared_memory_arbiter_user_pins
  import arb_pkg::*;
(
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  // system slave requests
  input  wire logic                 reg_select_n,
  input  wire logic                 shared_mem_request_n,
  output logic                      slave_mem_ack_n,
  // on-chip access to shared memory
  input  wire logic                 dev_mem_req,
  output logic                      dev_mem_grant,
  input  wire logic                 regs_busy,
  // bus mastership
  input  wire logic                 hold_ack,
  input  wire logic                 grant_ack_n,
  input  wire logic                 big_endian_mode,
  output logic                      size_ack_oe,
  // configuration
  input  wire logic [1:0]           cfg_usr_out,
  output logic [1:0]                cfg_usr_in,
  // user pins
  input  wire logic [1:0]           user_pins_in,
  output logic [1:0]                user_pins_out,
  output logic [1:0]                user_pins_oe
);
  typedef struct packed {
    arb_state_e state;
    logic       ack_n;
    logic       grant;
    logic       size_oe;
  } arb_s;

  arb_s st;
  arb_s next_st;
  arb_if link ();

  // --------------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------------
  // one place decides which states hand the shared path to the system; only the
  // acknowledge logic uses it, and the checks spell out their own conditions
  function automatic logic slave_owns(input arb_state_e s);
    return (s == st_sys_mem) || (s == st_sys_reg);
  endfunction

  // --------------------------------------------------------------------------
  // arbitration
  // --------------------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    unique case (st.state)
      st_idle:
      begin
        // device wins a tie: it was already waiting and is stalled only behind a system owner
        if (dev_mem_req)
          next_st.state = st_dev;
        else if (!shared_mem_request_n)
          next_st.state = st_sys_mem;
        else if (!reg_select_n && !regs_busy)
          next_st.state = st_sys_reg;
      end
      st_dev:
      begin
        // memory stays with the device until it drops its own request
        if (!dev_mem_req)
          next_st.state = st_idle;
      end
      st_sys_mem:
      begin
        // a pending device request waits here; it is never signalled back
        if (shared_mem_request_n)
          next_st.state = st_idle;
      end
      st_sys_reg:
      begin
        // register access does not touch memory but still blocks the device
        if (reg_select_n)
          next_st.state = st_idle;
      end
    endcase
    next_st.ack_n = !slave_owns(next_st.state);
    // grant is registered so the output comes straight from a flop
    next_st.grant = (next_st.state == st_dev);
    // the size-ack lines keep being driven in big-endian mode even after yielding;
    // the board must isolate them
    next_st.size_oe = big_endian_mode;
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      st.state   <= st_idle;
      st.ack_n   <= 1'b1;
      st.grant   <= 1'b0;
      st.size_oe <= 1'b0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // --------------------------------------------------------------------------
  // user pins
  // --------------------------------------------------------------------------
  assign link.rst_held     = sys_rst;
  assign link.bus_master   = hold_ack || !grant_ack_n;
  assign link.cfg_out_bits = cfg_usr_out;
  assign link.pin_in       = user_pins_in;

  user_pin_latch u_pins (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .up       (link.latch)
  );

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign slave_mem_ack_n = st.ack_n;
  assign dev_mem_grant   = st.grant;
  assign size_ack_oe     = st.size_oe;
  assign cfg_usr_in      = link.cfg_in_bits;
  assign user_pins_out   = link.pin_out;
  assign user_pins_oe    = link.pin_oe;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  // these check the registered outputs, some from st.state; they take the requests as legal,
  // so select and memory request are never low together, which the system owes us
  // a check that fires on an illegal overlap would point at the board, not here

  // a register access is answered when the registers are free
  chk_reg_ack: assert property (@(posedge core_clk) disable iff (sys_rst)
    st.state == st_idle && !dev_mem_req && shared_mem_request_n && !reg_select_n && !regs_busy
    |=> !slave_mem_ack_n)
    else $error("register select not acknowledged");

  // busy registers hold the acknowledge off
  chk_reg_busy_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    st.state == st_idle && !dev_mem_req && shared_mem_request_n && !reg_select_n && regs_busy
    |=> slave_mem_ack_n)
    else $error("register acknowledged while busy");

  // memory acknowledge stands while the request stands
  chk_mem_ack_stands: assert property (@(posedge core_clk) disable iff (sys_rst)
    !slave_mem_ack_n && !shared_mem_request_n
    |=> !slave_mem_ack_n)
    else $error("memory acknowledge dropped early");

  // register acknowledge stands while the select stands
  chk_reg_ack_stands: assert property (@(posedge core_clk) disable iff (sys_rst)
    !slave_mem_ack_n && !reg_select_n
    |=> !slave_mem_ack_n)
    else $error("register acknowledge dropped early");

  // the device wins a tie from idle
  chk_dev_first: assert property (@(posedge core_clk) disable iff (sys_rst)
    st.state == st_idle && dev_mem_req
    |=> dev_mem_grant && slave_mem_ack_n)
    else $error("device not granted first");

  // the grant ends once the device lets go
  chk_grant_release: assert property (@(posedge core_clk) disable iff (sys_rst)
    dev_mem_grant && !dev_mem_req
    |=> !dev_mem_grant)
    else $error("device grant not released");

  // a system memory owner keeps the device out
  chk_mem_blocks_dev: assert property (@(posedge core_clk) disable iff (sys_rst)
    !slave_mem_ack_n && !shared_mem_request_n
    |=> !dev_mem_grant)
    else $error("device granted during system memory access");

  // a system register owner keeps the device out as well
  chk_reg_blocks_dev: assert property (@(posedge core_clk) disable iff (sys_rst)
    !slave_mem_ack_n && !reg_select_n
    |=> !dev_mem_grant)
    else $error("device granted during register access");

  // little-endian style leaves the size-ack lines undriven
  chk_size_off: assert property (@(posedge core_clk) disable iff (sys_rst)
    !big_endian_mode
    |=> !size_ack_oe)
    else $error("size ack driven in little-endian style");

  // user pins are driven one cycle after mastership starts
  chk_pins_master: assert property (@(posedge core_clk) disable iff (sys_rst)
    hold_ack || !grant_ack_n
    |=> user_pins_oe == 2'h3)
    else $error("user pins not driven as master");

  // and released one cycle after it ends
  chk_pins_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
    !hold_ack && grant_ack_n
    |=> user_pins_oe == 2'h0)
    else $error("user pins driven while not master");


  chk_one_owner: assert property (@(posedge core_clk) disable iff (sys_rst)
    dev_mem_grant |-> slave_mem_ack_n) else $error("memory granted to two parties");
  chk_mem_ack: assert property (@(posedge core_clk) disable iff (sys_rst)
    st.state == st_idle && !dev_mem_req && !shared_mem_request_n |=> !slave_mem_ack_n)
    else $error("memory request not acknowledged");
  chk_ack_release: assert property (@(posedge core_clk) disable iff (sys_rst)
    !slave_mem_ack_n && shared_mem_request_n && reg_select_n |=> slave_mem_ack_n)
    else $error("acknowledge not released");
  chk_size_drive: assert property (@(posedge core_clk) disable iff (sys_rst)
    big_endian_mode |=> size_ack_oe) else $error("size ack not driven");
endmodule

// file: arb_pkg.sv
// constants and types for the shared memory arbiter and user pins
package arb_pkg;
  localparam int unsigned cfg_width   = 16;
  localparam int unsigned usr_in_lsb  = 8;
  localparam int unsigned usr_out_lsb = 11;
  localparam logic [1:0]  usr_reset   = 2'h0;
  localparam int unsigned gap_clocks  = 2;

  typedef enum logic [1:0] {st_idle, st_dev, st_sys_reg, st_sys_mem} arb_state_e;
endpackage

// file: arb_if.sv
// interface between the arbiter top and its user pin latch
interface arb_if;
  logic       rst_held;
  logic       bus_master;
  logic [1:0] cfg_out_bits;
  logic [1:0] pin_in;
  logic [1:0] cfg_in_bits;
  logic [1:0] pin_out;
  logic [1:0] pin_oe;

  modport top (output rst_held, output bus_master, output cfg_out_bits, output pin_in,
               input cfg_in_bits, input pin_out, input pin_oe);
  modport latch (input rst_held, input bus_master, input cfg_out_bits, input pin_in,
                 output cfg_in_bits, output pin_out, output pin_oe);
endinterface

// file: user_pin_latch.sv
// user pin capture at reset release and drive while bus master
module user_pin_latch
  import arb_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // link to top
  arb_if.latch      up
);
  typedef struct packed {
    logic [1:0] cfg_in_bits;
    logic [1:0] pin_out;
    logic [1:0] pin_oe;
  } latch_s;

  latch_s st;
  latch_s next_st;

  always_comb
  begin
    next_st = st;
    // follow pins while reset held; last sampled value is kept at release
    if (up.rst_held)
    begin
      next_st.cfg_in_bits = up.pin_in;
    end
    next_st.pin_oe  = up.bus_master ? 2'h3 : 2'h0;
    next_st.pin_out = up.cfg_out_bits;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      st.pin_out <= 2'h0;
      st.pin_oe  <= 2'h0;
      st.cfg_in_bits <= next_st.cfg_in_bits;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign up.cfg_in_bits = st.cfg_in_bits;
  assign up.pin_out     = st.pin_out;
  assign up.pin_oe      = st.pin_oe;

  chk_pin_drive_master: assert property (@(posedge core_clk) disable iff (sys_rst)
    up.bus_master |=> st.pin_oe == 2'h3) else $error("user pins not driven while master");
  chk_pin_value_cfg: assert property (@(posedge core_clk) disable iff (sys_rst)
    up.bus_master |=> st.pin_out == $past(up.cfg_out_bits)) else $error("user pin level wrong");
  chk_capture_hold: assert property (@(posedge core_clk)
    !up.rst_held && !sys_rst |=> $stable(st.cfg_in_bits)) else $error("captured bits changed");
  chk_capture_follow: assert property (@(posedge core_clk)
    up.rst_held |=> st.cfg_in_bits == $past(up.pin_in)) else $error("bits not following pins");
endmodule

// file: sys_master.sv
// system bus master model driving register select and memory request
module sys_master (
  // clock
  input  wire logic core_clk,
  // requests
  output logic      reg_select_n,
  output logic      shared_mem_request_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {reg_select_n, shared_mem_request_n} = 2'h3;
  // mem picks the line; both are never low at once, and an assert waits out the gap
  task automatic req(input logic mem, input logic on);
    repeat (on ? 3 : 1) @(posedge core_clk);
    #1;
    if (mem)
      shared_mem_request_n = !on;
    else
      reg_select_n = !on;
  endtask
endmodule

// file: shared_memory_arbiter_user_pins_bench.sv
// self-checking bench for the shared memory arbiter and user pins
module shared_memory_arbiter_user_pins_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk = 0, sys_rst = 1, dev_mem_req = 0, regs_busy = 0;
  logic       hold_ack = 0, grant_ack_n = 1, big_endian_mode = 0;
  logic       reg_select_n, shared_mem_request_n, slave_mem_ack_n, dev_mem_grant, size_ack_oe;
  logic [1:0] cfg_usr_out = 2'h0, ext = 2'h2, cfg_usr_in, user_pins_out, user_pins_oe;
  // pin level: device drive wins, otherwise the board level
  wire  [1:0] user_pins_in = {user_pins_oe[1] === 1'b1 ? user_pins_out[1] : ext[1],
                              user_pins_oe[0] === 1'b1 ? user_pins_out[0] : ext[0]};
  int         miscompares = 0, n_checks = 0;

  shared_memory_arbiter_user_pins uut (.core_clk, .sys_rst, .reg_select_n, .shared_mem_request_n,
    .slave_mem_ack_n, .dev_mem_req, .dev_mem_grant, .regs_busy, .hold_ack, .grant_ack_n,
    .big_endian_mode, .size_ack_oe, .cfg_usr_out, .cfg_usr_in, .user_pins_in, .user_pins_out,
    .user_pins_oe);
  sys_master sys (.core_clk, .reg_select_n, .shared_mem_request_n);

  initial forever #2 core_clk = ~core_clk;

  task automatic tk(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic cmp(input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial
  begin
    tk(5);
    sys_rst = 0;
    ext = 2'h1;
    tk(2);
    cmp(cfg_usr_in, 2'h2);
    cmp(user_pins_oe, 2'h0);
    $display("pin capture done");
    sys.req(1, 1);
    cmp(slave_mem_ack_n, 1'b1);
    tk(1);
    cmp(slave_mem_ack_n, 1'b0);
    sys.req(1, 0);
    cmp(slave_mem_ack_n, 1'b0);
    tk(1);
    cmp(slave_mem_ack_n, 1'b1);
    regs_busy = 1;
    sys.req(0, 1);
    tk(3);
    cmp(slave_mem_ack_n, 1'b1);
    regs_busy = 0;
    tk(1);
    cmp(slave_mem_ack_n, 1'b0);
    sys.req(0, 0);
    tk(1);
    cmp(slave_mem_ack_n, 1'b1);
    $display("slave access done");
    dev_mem_req = 1;
    tk(1);
    cmp(dev_mem_grant, 1'b1);
    sys.req(1, 1);
    tk(2);
    cmp(slave_mem_ack_n, 1'b1);
    dev_mem_req = 0;
    tk(2);
    cmp(dev_mem_grant, 1'b0);
    cmp(slave_mem_ack_n, 1'b0);
    sys.req(1, 0);
    tk(1);
    $display("arbitration done");
    for (int m = 0; m < 2; m++)
    begin
      big_endian_mode = m[0];
      cfg_usr_out = m[0] ? 2'h2 : 2'h1;
      hold_ack = !m[0];
      grant_ack_n = !m[0];
      tk(1);
      cmp(user_pins_oe, 2'h3);
      cmp(user_pins_out, cfg_usr_out);
      cmp(size_ack_oe, m[0]);
      hold_ack = 0;
      grant_ack_n = 1;
      tk(2);
      cmp(user_pins_oe, 2'h0);
      cmp(cfg_usr_in, 2'h2);
    end
    $display("bus master pins done");
    sys_rst = 1;
    tk(2);
    cmp(slave_mem_ack_n, 1'b1);
    cmp(user_pins_oe, 2'h0);
    sys_rst = 0;
    ext = 2'h0;
    tk(1);
    cmp(cfg_usr_in, 2'h1);
    $display("second reset done");
    finish_test;
  end

  // a hang counts as a mismatch
  initial
  begin
    #100000;
    miscompares++;
    finish_test;
  end
endmodule
